// [rtl/sid_pkg.sv]
// Shared constants and types for the subtract instruction datapath
package sid_pkg;
    localparam int          DATA_W       = 8;
    localparam int          BANK_W_DEF   = 4;
    localparam int          BUS_DW       = 32;
    localparam int          BUS_AW       = 14;
    localparam int          WORD_LSB     = 2;

    // Register byte offsets
    localparam logic [13:0] REG_ACC      = 14'h0000;
    localparam logic [13:0] REG_BANK     = 14'h0004;
    localparam logic [13:0] REG_CMD      = 14'h0008;
    localparam logic [13:0] REG_STATUS   = 14'h000C;
    // Address bit that selects the file-register window
    localparam int          MEM_SEL_BIT  = 13;

    // Command word fields
    localparam int          CMD_OPND_LSB = 0;
    localparam int          CMD_FILE_BIT = 8;
    localparam int          CMD_DEST_BIT = 9;
    localparam int          CMD_BANK_BIT = 10;

    // Status word fields; the flag vector uses the same positions
    localparam int          ST_C         = 0;
    localparam int          ST_DC        = 1;
    localparam int          ST_Z         = 2;
    localparam int          ST_OV        = 3;
    localparam int          ST_N         = 4;
    localparam int          FLAG_W       = 5;
    localparam int          ST_BUSY      = 8;

    localparam logic [7:0]  ACC_RST      = 8'h00;
    localparam logic [3:0]  BANK_RST     = 4'h0;
    localparam logic [3:0]  SHARED_BANK  = 4'h0;
    localparam logic [4:0]  FLAGS_RST    = 5'h00;
    localparam logic        DEST_ACC     = 1'b0;
    localparam logic        DEST_FILE    = 1'b1;
    localparam logic        BANK_SHARED  = 1'b0;
    localparam logic        BANK_BANKED  = 1'b1;

    localparam int          PHASES       = 4;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } sid_phase_e;
endpackage

// [rtl/sid_alu_if.sv]
// Operand and result bundle between the sequencer and the subtractor
`timescale 1ns/100ps
`default_nettype none
interface sid_alu_if;
    import sid_pkg::*;
    logic [DATA_W-1:0] minuend;
    logic [DATA_W-1:0] subtrahend;
    logic [DATA_W-1:0] diff;
    logic [FLAG_W-1:0] flags;

    modport alu (
        input  minuend,
        input  subtrahend,
        output diff,
        output flags
    );
    modport core (
        output minuend,
        output subtrahend,
        input  diff,
        input  flags
    );
endinterface
`default_nettype wire

// [rtl/sid_sub.sv]
// Two's complement subtractor with status flag generation
`timescale 1ns/100ps
`default_nettype none
module sid_sub
    import sid_pkg::*;
(
    sid_alu_if.alu bus
);
    logic [DATA_W:0]   full_sum;
    logic [4:0]        low_sum;

    // Complement method: a + ~b + 1, carry out means no borrow
    always_comb begin
        full_sum = {1'b0, bus.minuend} + {1'b0, ~bus.subtrahend}
                   + {{DATA_W{1'b0}}, 1'b1};
        low_sum  = {1'b0, bus.minuend[3:0]} + {1'b0, ~bus.subtrahend[3:0]}
                   + 5'h01;
    end

    assign bus.diff = full_sum[DATA_W-1:0];
    // Zero and negative follow the truncated result; carry is the ninth sum bit, digit carry the nibble carry
    assign bus.flags[ST_C]  = full_sum[DATA_W];
    assign bus.flags[ST_DC] = low_sum[4];
    assign bus.flags[ST_Z]  = (full_sum[DATA_W-1:0] == '0);
    assign bus.flags[ST_N]  = full_sum[DATA_W-1];
    assign bus.flags[ST_OV] = (bus.minuend[DATA_W-1]
                               ^ bus.subtrahend[DATA_W-1])
                            & (full_sum[DATA_W-1] ^ bus.minuend[DATA_W-1]);
endmodule // sid_sub
`default_nettype wire

// [rtl/sid_core.sv]
// Subtract instruction datapath with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
module sid_core #(
    parameter int BANK_W = sid_pkg::BANK_W_DEF
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic [sid_pkg::BUS_AW-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [sid_pkg::BUS_DW-1:0] avs_writedata,
    output var  logic [sid_pkg::BUS_DW-1:0] avs_readdata,
    output var  logic                      avs_waitrequest
);
    import sid_pkg::*;

    localparam int EA_W  = BANK_W + DATA_W;
    localparam int DEPTH = 1 << EA_W;

    sid_phase_e        phase_r;
    sid_phase_e        phase_nxt;
    logic [DATA_W-1:0] acc_r;
    logic [BANK_W-1:0] bank_r;
    logic [DATA_W-1:0] opnd_r;
    logic              op_file_r;
    logic              dest_r;
    logic              bank_sel_r;
    logic [EA_W-1:0]   ea_r;
    logic [DATA_W-1:0] fval_r;
    logic [DATA_W-1:0] res_r;
    logic [FLAG_W-1:0] pend_flags_r;
    logic [FLAG_W-1:0] flags_r;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [BUS_DW-1:0] rd_nxt;
    logic [EA_W-1:0]   bus_idx;
    logic              req;
    logic              take;
    logic              is_mem;
    logic              cmd_wr;
    logic              acc_wr;
    logic              bank_wr;
    logic              mem_wr;
    logic              wr_acc_res;
    logic              wr_mem_res;

    sid_alu_if alu_bus ();

    sid_sub u_sub (
        .bus (alu_bus.alu)
    );

    assign alu_bus.minuend    = fval_r;
    assign alu_bus.subtrahend = acc_r;

    assign req     = avs_read | avs_write;
    // Transfer completes at the edge where waitrequest is seen low
    assign take    = req & ~avs_waitrequest;
    assign is_mem  = avs_address[MEM_SEL_BIT];
    // Bit 13 selects the window, so only bits 12..2 index the file: the
    // bus reaches banks 0 to 7, the upper banks only through instructions
    assign bus_idx = EA_W'(avs_address[MEM_SEL_BIT-1:WORD_LSB]);
    assign cmd_wr  = take & avs_write & ~is_mem & (avs_address == REG_CMD);
    assign acc_wr  = take & avs_write & ~is_mem & (avs_address == REG_ACC);
    assign bank_wr = take & avs_write & ~is_mem & (avs_address == REG_BANK);
    assign mem_wr  = take & avs_write & is_mem;

    assign wr_acc_res = (phase_r == PH_Q4)
                      & (~op_file_r | (dest_r == DEST_ACC));
    assign wr_mem_res = (phase_r == PH_Q4) & op_file_r & (dest_r == DEST_FILE);

    // Phase sequencer: one instruction cycle of four phases
    always_comb begin
        case (phase_r)
            PH_IDLE: phase_nxt = cmd_wr ? PH_Q1 : PH_IDLE;
            PH_Q1:   phase_nxt = PH_Q2;
            PH_Q2:   phase_nxt = PH_Q3;
            PH_Q3:   phase_nxt = PH_Q4;
            PH_Q4:   phase_nxt = PH_IDLE;
            default: phase_nxt = PH_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= PH_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Command latch; the bus stalls while busy, so no overwrite occurs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            opnd_r     <= '0;
            op_file_r  <= 1'b0;
            dest_r     <= DEST_FILE;
            bank_sel_r <= BANK_BANKED;
        end else if (cmd_wr) begin
            opnd_r     <= avs_writedata[CMD_OPND_LSB +: DATA_W];
            op_file_r  <= avs_writedata[CMD_FILE_BIT];
            dest_r     <= avs_writedata[CMD_DEST_BIT];
            bank_sel_r <= avs_writedata[CMD_BANK_BIT];
        end
    end

    // Decode phase forms the effective file address
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ea_r <= '0;
        end else if (phase_r == PH_Q1) begin
            if (bank_sel_r == BANK_SHARED) begin
                ea_r <= {SHARED_BANK[BANK_W-1:0], opnd_r};
            end else begin
                ea_r <= {bank_r, opnd_r};
            end
        end
    end

    // Read phase fetches the literal or the file register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fval_r <= '0;
        end else if (phase_r == PH_Q2) begin
            fval_r <= op_file_r ? mem[ea_r] : opnd_r;
        end
    end

    // Process phase captures difference and flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_r        <= '0;
            pend_flags_r <= FLAGS_RST;
        end else if (phase_r == PH_Q3) begin
            res_r        <= alu_bus.diff;
            pend_flags_r <= alu_bus.flags;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= FLAGS_RST;
        end else if (phase_r == PH_Q4) begin
            flags_r <= pend_flags_r;
        end
    end

    // Write phase; bus writes cannot collide, they stall while busy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= ACC_RST;
        end else if (wr_acc_res) begin
            acc_r <= res_r;
        end else if (acc_wr) begin
            acc_r <= avs_writedata[DATA_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_r <= BANK_RST[BANK_W-1:0];
        end else if (bank_wr) begin
            bank_r <= avs_writedata[BANK_W-1:0];
        end
    end

    // File registers carry no reset, like ordinary data memory
    always_ff @(posedge sys_clk) begin
        if (wr_mem_res) begin
            mem[ea_r] <= res_r;
        end else if (mem_wr) begin
            mem[bus_idx] <= avs_writedata[DATA_W-1:0];
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_nxt = '0;
        if (is_mem) begin
            rd_nxt[DATA_W-1:0] = mem[bus_idx];
        end else begin
            case (avs_address)
                REG_ACC:    rd_nxt[DATA_W-1:0] = acc_r;
                REG_BANK:   rd_nxt[BANK_W-1:0] = bank_r;
                REG_STATUS: begin
                    rd_nxt[FLAG_W-1:0] = flags_r;
                    rd_nxt[ST_BUSY]    = (phase_r != PH_IDLE);
                end
                default:    rd_nxt = '0;
            endcase
        end
    end

    // Every access stalls until the instruction has retired
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (req && phase_r == PH_IDLE) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence insn_walk_s;
        phase_r == PH_Q1 ##1 phase_r == PH_Q2 ##1 phase_r == PH_Q3
        ##1 phase_r == PH_Q4;
    endsequence

    phase_order_a: assert property (
        cmd_wr |=> insn_walk_s ##1 phase_r == PH_IDLE)
        else $error("phase order broken");

    one_cycle_a: assert property (
        phase_r == PH_Q1 |-> ##3 phase_r == PH_Q4 ##1 phase_r == PH_IDLE)
        else $error("instruction not one cycle");

    lit_result_a: assert property (
        phase_r == PH_Q4 && !op_file_r
        |=> acc_r == DATA_W'(opnd_r - $past(acc_r)))
        else $error("literal subtract wrong");

    file_to_reg_a: assert property (
        phase_r == PH_Q4 && op_file_r && dest_r == DEST_FILE
        |=> mem[ea_r] == DATA_W'(fval_r - acc_r) && $stable(acc_r))
        else $error("file result not in file");

    file_to_acc_a: assert property (
        phase_r == PH_Q4 && op_file_r && dest_r == DEST_ACC
        |=> acc_r == DATA_W'(fval_r - $past(acc_r)))
        else $error("file result not in accumulator");

    shared_bank_a: assert property (
        phase_r == PH_Q2 && bank_sel_r == BANK_SHARED
        |-> ea_r == {SHARED_BANK[BANK_W-1:0], opnd_r})
        else $error("shared bank address wrong");

    banked_addr_a: assert property (
        phase_r == PH_Q2 && bank_sel_r == BANK_BANKED
        |-> ea_r == {bank_r, opnd_r})
        else $error("banked address wrong");

    positive_flags_a: assert property (
        phase_r == PH_Q4 && fval_r > acc_r && !res_r[DATA_W-1]
        |=> flags_r[ST_C] && !flags_r[ST_Z] && !flags_r[ST_N])
        else $error("positive result flags wrong");

    zero_neg_a: assert property (
        phase_r == PH_Q4 |=> flags_r[ST_Z] == ($past(res_r) == '0)
        && flags_r[ST_N] == $past(res_r[DATA_W-1])
        && flags_r[ST_C] == ($past(fval_r) >= $past(acc_r)))
        else $error("zero or negative flag wrong");

    nibble_borrow_a: assert property (
        phase_r == PH_Q4
        |=> flags_r[ST_DC] == ($past(fval_r[3:0]) >= $past(acc_r[3:0])))
        else $error("digit carry wrong");
endmodule // sid_core
`default_nettype wire

// [testbench/sid_core_tb.sv]
// Self-checking bench for the subtract instruction datapath
`timescale 1ns/100ps
`default_nettype none
module subtract_instruction_datapath_tb;
    import sid_pkg::*;
    logic              sys_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [BUS_AW-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [BUS_DW-1:0] avs_writedata = '0;
    logic [BUS_DW-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic [BUS_DW-1:0] rd;
    int                mismatches = 0;
    int                checks_done = 0;
    int                acc_m;
    int                bank_m;
    int                edges;
    int                mem_m [int];
    int                dk [5] = '{2, 128, 128, 0, 16};
    int                da [5] = '{1, 128, 1, 1, 1};

    sid_core sid_core_inst (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );

    always #20 sys_clk = ~sys_clk;

    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Entered just after an edge; values read right after an edge are the
    // ones that edge sampled, so no race with the slave's own flops
    task automatic bus(input logic wr, input logic [13:0] a,
                       input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        edges = 0;
        do begin
            @(posedge sys_clk);
            edges++;
            if (edges > 40) begin
                mismatches++;
                end_of_test();
            end
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Returns flags from bit 8 up and the difference in the low byte
    function automatic int sub_m(input int m, input int a);
        int d;
        int f;
        d = (m - a) & 255;
        f = 0;
        if (m >= a) f |= 1 << ST_C;
        if ((m & 15) >= (a & 15)) f |= 1 << ST_DC;
        if (d == 0) f |= 1 << ST_Z;
        if (((m ^ a) & (m ^ d) & 128) != 0) f |= 1 << ST_OV;
        if (d >= 128) f |= 1 << ST_N;
        return (f << 8) | d;
    endfunction

    function automatic logic [13:0] fa(input int idx);
        return 14'h2000 | 14'(idx << 2);
    endfunction

    task automatic run(input int k, input int op, input int dst,
                       input int ab);
        int idx;
        int res;
        idx = (ab == 1) ? ((bank_m << 8) | k) : k;
        res = sub_m(op ? mem_m[idx] : k, acc_m);
        bus(1'b1, REG_CMD, 32'(k | op << CMD_FILE_BIT
            | dst << CMD_DEST_BIT | ab << CMD_BANK_BIT));
        bus(1'b0, REG_STATUS, '0);
        chk("stall", 32'(edges >= 4 && edges <= 5), 32'h1);
        chk("status", rd, 32'(res >> 8));
        if (op == 1 && dst == 1) mem_m[idx] = res & 255;
        else acc_m = res & 255;
        bus(1'b0, REG_ACC, '0);
        chk("acc", rd, 32'(acc_m));
        if (op == 1) begin
            bus(1'b0, fa(idx), '0);
            chk("file", rd, 32'(mem_m[idx]));
        end
    endtask

    initial begin
        void'($urandom(32'hE9E6));
        bank_m = 0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // Read-only and unmapped writes must leave nothing behind
        bus(1'b1, REG_STATUS, 32'hFF);
        bus(1'b1, 14'h0010, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 14'(i * 4), '0);
            chk("reset", rd, 32'h0);
        end
        bus(1'b1, REG_BANK, 32'hFF);
        bus(1'b0, REG_BANK, '0);
        chk("bank", rd, 32'h0F);
        bus(1'b1, REG_BANK, 32'h0);
        // Positive, zero, overflow and borrow corners of the literal op
        for (int i = 0; i < 5; i++) begin
            acc_m = da[i];
            bus(1'b1, REG_ACC, 32'(acc_m));
            run(dk[i], 0, 1, i & 1);
        end
        for (int i = 0; i < 48; i++) begin
            int k;
            int hi;
            k = $urandom & 255;
            acc_m = $urandom & 255;
            bank_m = $urandom & 7;
            hi = (bank_m << 8) | k;
            bus(1'b1, REG_ACC, 32'(acc_m));
            bus(1'b1, REG_BANK, 32'(bank_m));
            mem_m[k] = $urandom & 255;
            bus(1'b1, fa(k), 32'(mem_m[k]));
            mem_m[hi] = (i % 8 == 7) ? acc_m : ($urandom & 255);
            bus(1'b1, fa(hi), 32'(mem_m[hi]));
            run(k, i & 1, (i >> 1) & 1, (i >> 2) & 1);
        end
        end_of_test();
    end
endmodule // subtract_instruction_datapath_tb
`default_nettype wire
